//--- verilog/aig_pkg.sv
// Package: opcodes, flag layout and reset values for the ALU group
package aig_pkg;

	localparam int DATA_W = 8;
	localparam int FILE_IDX_W = 7;

	// Status flag positions inside the flag vector
	localparam int FLAG_C_POS = 0;
	localparam int FLAG_DC_POS = 1;
	localparam int FLAG_Z_POS = 2;

	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] TMODE_RESET = 8'hFF;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic [7:0] NIB_LO = 8'h0F;

	typedef enum logic [2:0]
	{
		AIG_OP_NONE = 3'b000,
		AIG_OP_SUB_IMM = 3'b001,
		AIG_OP_LD_TMODE = 3'b010,
		AIG_OP_RD_TMODE = 3'b011,
		AIG_OP_SWAP = 3'b100,
		AIG_OP_XOR_REG = 3'b101,
		AIG_OP_XOR_IMM = 3'b110
	} aig_op_t;

	typedef struct packed
	{
		aig_op_t op;
		logic dest;
		logic [6:0] idx;
		logic [7:0] imm;
		logic [7:0] reg_val;
	} aig_instr_t;

	typedef struct packed
	{
		logic wr;
		logic [6:0] idx;
		logic [7:0] data;
	} aig_fwr_t;

	typedef struct packed
	{
		logic [7:0] acc;
		logic [7:0] tmode;
		logic [2:0] flags;
		aig_fwr_t fwr;
	} aig_state_t;

endpackage

//--- verilog/aig_alu.sv
// Datapath for the accumulator instruction group
// Operation
// - Subtract from immediate: imm minus accumulator into accumulator.
// - Subtract from immediate updates carry, half carry and zero only.
// - Load timer mode copies accumulator to timer mode, flags untouched.
// - Read timer mode copies timer mode to accumulator, flags untouched.
// - Nibble swap exchanges operand nibbles, index 0..127, no flag change.
// - Nibble swap result to accumulator when d is 0, register when 1.
// - Register XOR with accumulator, zero flag only, destination by d.
// - Immediate XOR with accumulator into accumulator, zero flag only.
module aig_alu
	import aig_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire aig_instr_t INSTR_I,
	output aig_fwr_t FWR_O,
	output logic [7:0] ACC_O,
	output logic [7:0] TMODE_O,
	output logic [2:0] FLAGS_O
);

	aig_state_t state;
	aig_state_t next_state;

	always_comb
	begin
		logic [8:0] diff;
		logic [4:0] diff_lo;
		logic [7:0] res;
		diff = {1'b0, INSTR_I.imm} + {1'b0, ~state.acc} + 9'h001;
		diff_lo = {1'b0, INSTR_I.imm[3:0]} + {1'b0, ~state.acc[3:0]} + 5'h01;
		res = 8'h00;
		next_state = state;
		// Write strobe is a one-cycle pulse
		next_state.fwr.wr = 1'b0;
		next_state.fwr.idx = INSTR_I.idx;
		case (INSTR_I.op)
			AIG_OP_SUB_IMM:
			begin
				next_state.acc = diff[7:0];
				// Carry out of the add means no borrow
				next_state.flags[FLAG_C_POS] = diff[8];
				next_state.flags[FLAG_DC_POS] = diff_lo[4];
				next_state.flags[FLAG_Z_POS] = diff[7:0] == 8'h00;
			end
			AIG_OP_LD_TMODE:
				next_state.tmode = state.acc;
			AIG_OP_RD_TMODE:
				next_state.acc = state.tmode;
			AIG_OP_SWAP:
			begin
				res = {INSTR_I.reg_val[3:0], INSTR_I.reg_val[7:4]};
				if (INSTR_I.dest)
				begin
					next_state.fwr.wr = 1'b1;
					next_state.fwr.data = res;
				end
				else
					next_state.acc = res;
			end
			AIG_OP_XOR_REG:
			begin
				res = state.acc ^ INSTR_I.reg_val;
				next_state.flags[FLAG_Z_POS] = res == 8'h00;
				if (INSTR_I.dest)
				begin
					next_state.fwr.wr = 1'b1;
					next_state.fwr.data = res;
				end
				else
					next_state.acc = res;
			end
			AIG_OP_XOR_IMM:
			begin
				res = state.acc ^ INSTR_I.imm;
				next_state.acc = res;
				next_state.flags[FLAG_Z_POS] = res == 8'h00;
			end
			default:
				next_state.acc = state.acc;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			state.acc <= ACC_RESET;
			state.tmode <= TMODE_RESET;
			state.flags <= FLAGS_RESET;
			state.fwr <= '0;
		end
		else
			state <= next_state;
	end

	assign FWR_O = state.fwr;
	assign ACC_O = state.acc;
	assign TMODE_O = state.tmode;
	assign FLAGS_O = state.flags;

	AST_SUB_RESULT: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SUB_IMM
		|=> ACC_O == 8'($past(INSTR_I.imm) - $past(ACC_O)))
		else $error("Subtract result wrong");

	AST_SUB_CARRY: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SUB_IMM
		|=> FLAGS_O[FLAG_C_POS] == ($past(INSTR_I.imm) >= $past(ACC_O)))
		else $error("Subtract carry wrong");

	AST_SUB_HALF: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SUB_IMM
		|=> FLAGS_O[FLAG_DC_POS]
		== ($past(INSTR_I.imm[3:0]) >= $past(ACC_O[3:0])))
		else $error("Subtract half carry wrong");

	AST_SUB_ZERO: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SUB_IMM
		|=> FLAGS_O[FLAG_Z_POS] == (ACC_O == 8'h00))
		else $error("Subtract zero flag wrong");

	AST_SUB_NO_WRITE: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SUB_IMM
		|=> !FWR_O.wr && $stable(TMODE_O))
		else $error("Subtract touched other state");

	AST_LD_TMODE: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_LD_TMODE
		|=> TMODE_O == $past(ACC_O) && $stable(FLAGS_O))
		else $error("Timer mode load wrong");

	AST_LD_TMODE_KEEP: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_LD_TMODE
		|=> $stable(ACC_O) && !FWR_O.wr)
		else $error("Timer mode load touched accumulator");

	AST_TMODE_ONLY_LD: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op != AIG_OP_LD_TMODE
		|=> $stable(TMODE_O))
		else $error("Timer mode changed without a load");

	AST_RD_TMODE: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_RD_TMODE
		|=> ACC_O == $past(TMODE_O) && $stable(FLAGS_O))
		else $error("Timer mode read wrong");

	AST_RD_TMODE_KEEP: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_RD_TMODE
		|=> $stable(TMODE_O) && !FWR_O.wr)
		else $error("Timer mode read touched other state");

	AST_SWAP_ACC: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SWAP && !INSTR_I.dest
		|=> ACC_O[7:4] == $past(INSTR_I.reg_val[3:0])
		&& ACC_O[3:0] == $past(INSTR_I.reg_val[7:4])
		&& !FWR_O.wr && $stable(FLAGS_O))
		else $error("Swap to accumulator wrong");

	AST_SWAP_REG: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SWAP && INSTR_I.dest
		|=> FWR_O.wr && FWR_O.idx == $past(INSTR_I.idx)
		&& $stable(ACC_O)
		&& FWR_O.data[7:4] == $past(INSTR_I.reg_val[3:0])
		&& FWR_O.data[3:0] == $past(INSTR_I.reg_val[7:4]))
		else $error("Swap to register wrong");

	AST_SWAP_FLAGS: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_SWAP
		|=> $stable(FLAGS_O) && $stable(TMODE_O))
		else $error("Swap changed a flag");

	AST_XOR_REG: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_XOR_REG && INSTR_I.dest
		|=> FWR_O.wr
		&& FWR_O.data == ($past(ACC_O) ^ $past(INSTR_I.reg_val))
		&& FLAGS_O[FLAG_Z_POS] == (FWR_O.data == 8'h00)
		&& FLAGS_O[1:0] == $past(FLAGS_O[1:0]))
		else $error("Register XOR wrong");

	AST_XOR_REG_ACC: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_XOR_REG && !INSTR_I.dest
		|=> !FWR_O.wr
		&& ACC_O == ($past(ACC_O) ^ $past(INSTR_I.reg_val))
		&& FLAGS_O[FLAG_Z_POS] == (ACC_O == 8'h00)
		&& FLAGS_O[1:0] == $past(FLAGS_O[1:0]))
		else $error("Register XOR to accumulator wrong");

	AST_XOR_REG_KEEP: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_XOR_REG && INSTR_I.dest
		|=> $stable(ACC_O) && FWR_O.idx == $past(INSTR_I.idx))
		else $error("Register XOR changed the accumulator");

	AST_XOR_IMM: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_XOR_IMM
		|=> ACC_O == ($past(ACC_O) ^ $past(INSTR_I.imm))
		&& FLAGS_O[FLAG_Z_POS] == (ACC_O == 8'h00)
		&& FLAGS_O[1:0] == $past(FLAGS_O[1:0]))
		else $error("Immediate XOR wrong");

	AST_XOR_IMM_NO_WRITE: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		INSTR_I.op == AIG_OP_XOR_IMM
		|=> !FWR_O.wr && $stable(TMODE_O))
		else $error("Immediate XOR touched other state");

	AST_WR_SOURCE: assert property (
		@(posedge CLK_I) disable iff (!RESETN_I)
		FWR_O.wr
		|-> $past(INSTR_I.dest)
		&& ($past(INSTR_I.op) == AIG_OP_SWAP
		|| $past(INSTR_I.op) == AIG_OP_XOR_REG))
		else $error("Write-back without a register destination");

endmodule

//--- dv/aig_bench.sv
// Self-checking random bench for the accumulator instruction group
module accumulator_alu_instr_group_bench import aig_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b1;
	aig_instr_t instr = '0;
	aig_fwr_t fwr;
	logic [7:0] acc;
	logic [7:0] tmode;
	logic [2:0] flags;
	aig_state_t m;
	logic [31:0] seed = 32'h905DE696;
	int n_mismatch = 0;
	int compares = 0;
	aig_alu u_aig_alu(.CLK_I(clk), .RESETN_I(rst_n), .INSTR_I(instr),
		.FWR_O(fwr), .ACC_O(acc), .TMODE_O(tmode), .FLAGS_O(flags));
	always #5 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic aig_state_t model(aig_state_t s, aig_instr_t i);
		aig_state_t n;
		logic [7:0] r;
		n = s;
		n.fwr.wr = 1'b0;
		r = (i.op == AIG_OP_SWAP) ? {i.reg_val[3:0], i.reg_val[7:4]} :
			s.acc ^ ((i.op == AIG_OP_XOR_IMM) ? i.imm : i.reg_val);
		case (i.op)
			AIG_OP_SUB_IMM:
			begin
				n.acc = i.imm - s.acc;
				n.flags = {n.acc == 8'h00, i.imm[3:0] >= s.acc[3:0],
					i.imm >= s.acc};
			end
			AIG_OP_LD_TMODE: n.tmode = s.acc;
			AIG_OP_RD_TMODE: n.acc = s.tmode;
			AIG_OP_SWAP, AIG_OP_XOR_REG, AIG_OP_XOR_IMM:
			begin
				if (i.op != AIG_OP_SWAP)
					n.flags[FLAG_Z_POS] = (r == 8'h00);
				if (i.dest && i.op != AIG_OP_XOR_IMM)
					n.fwr = {1'b1, i.idx, r};
				else
					n.acc = r;
			end
			default: ;
		endcase
		return n;
	endfunction
	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic cmp();
		chk("acc", m.acc, acc);
		chk("tmode", m.tmode, tmode);
		chk("flags", {5'h00, m.flags}, {5'h00, flags});
		chk("wr", {7'h00, m.fwr.wr}, {7'h00, fwr.wr});
		if (m.fwr.wr)
		begin
			chk("idx", {1'b0, m.fwr.idx}, {1'b0, fwr.idx});
			chk("data", m.fwr.data, fwr.data);
		end
	endtask
	task automatic issue(aig_instr_t i);
		aig_state_t nx;
		nx = model(m, i);
		instr = i;
		@(posedge clk);
		#1;
		m = nx;
		cmp();
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		instr = '0;
		m = {ACC_RESET, TMODE_RESET, FLAGS_RESET, 16'h0000};
		#1;
		cmp(); // Async reset must act without an edge
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		// Reset falls after time zero so the flops see a real edge
		#1;
		do_reset();
		issue('{AIG_OP_SUB_IMM, 1'b0, 7'h00, 8'h00, 8'h00});
		issue('{AIG_OP_SUB_IMM, 1'b0, 7'h00, 8'h10, 8'h00});
		issue('{AIG_OP_SUB_IMM, 1'b0, 7'h00, 8'h0F, 8'h00});
		issue('{AIG_OP_LD_TMODE, 1'b0, 7'h00, 8'h00, 8'h00});
		issue('{AIG_OP_XOR_IMM, 1'b0, 7'h00, 8'hFF, 8'h00});
		issue('{AIG_OP_RD_TMODE, 1'b0, 7'h00, 8'h00, 8'h00});
		issue('{AIG_OP_SWAP, 1'b1, 7'h7F, 8'h00, 8'hA5});
		issue('{AIG_OP_SWAP, 1'b0, 7'h00, 8'h00, 8'h3C});
		issue('{AIG_OP_XOR_REG, 1'b1, 7'h05, 8'h00, m.acc});
		issue('{AIG_OP_XOR_REG, 1'b0, 7'h06, 8'h00, m.acc});
		issue('{aig_op_t'(3'h7), 1'b1, 7'h01, 8'h55, 8'h55});
		for (int k = 0; k < 3000; k++)
		begin
			seed = xs(seed);
			issue(aig_instr_t'(seed[26:0]));
			if (k == 1500)
				do_reset(); // Second reset in mid-run
		end
		tally_and_finish();
	end
endmodule
